// [shared/mst_defs.vh]
// Constants for the sequencer and time-base block.
// Assumes one instruction-cycle clock and a register bus of Avalon-MM form.
// Contract
// RL1 - Table load fetches ROM byte at PC[9:8], accumulator, RAM nibble into latch.
// RL2 - Table load pushes PC+1, sets PC[7:4] from A, PC[3:0] from RAM.
// RL3 - After latching the byte the stack pops, restoring sequential execution.
// RL4 - Net effect of push then pop: bottom level takes former middle value.
// RL5 - Table load takes exactly two instruction cycles.
// RL6 - 10-bit time-base counter steps every cycle; wrap sets sticky overflow latch.
// RL7 - Skip-on-timer skips next instruction and clears latch when set.
// RL8 - Skipped instructions still spend one cycle per byte.
// RL9 - 10-bit program counter carries across 64-word page boundaries.
// RL10 - Page jumps in last page word use the next page as current.
// RL11 - Indirect ops in last word of pages 3,7,11,15 use next group.
// RL12 - Program image must start with clear-accumulator at address zero.
// RL13 - Clock-input code selects divisor 16, 8 or 4.
// RL14 - Clock-aux pin code 0..4; code 0 barred with clock-input 4 or 5. Aux codes 5..7 are stored without setting the error flag.
// RL15 - Function option 0 normal, 1 parallel bus; zero on reduced-pin part.
// RL16 - Serial out forced high enters test mode; serial in picks RAM or ROM test.
// RL17 - Serial counter mode frees serial data and clock pins as outputs.
// RL18 - Indirect jump loads PC[7:0] from ROM, keeps PC[9:8], two cycles.
// RL19 - Return stack is three 10-bit levels, last in first out.
// RL20 - Overflow coinciding with skip clear leaves latch set.
`ifndef MST_DEFS_VH
`define MST_DEFS_VH
`define MST_PC_W 10
`define MST_TB_W 10
`define MST_PC_RST 10'h000
`define MST_REG_CTRL 4'h0
`define MST_REG_OPT 4'h1
`define MST_REG_STAT 4'h2
`define MST_REG_PC 4'h3
`define MST_REG_TABLE 4'h4
`define MST_REG_STK0 4'h5
`define MST_REG_STK1 4'h6
`define MST_REG_STK2 4'h7
`define MST_REG_TBASE 4'h8
`define MST_OP_NONE 3'h0
`define MST_OP_TABLE 3'h1
`define MST_OP_SKT 3'h2
`define MST_OP_JIND 3'h3
`define MST_OP_JPAGE 3'h4
`define MST_OP_CALLP 3'h5
`define MST_OP_RET 3'h6
`define MST_OP_SEQ 3'h7
`define MST_CTRL_GO 0
`define MST_STAT_OVF 0
`define MST_STAT_BUSY 1
`define MST_STAT_OPTERR 2
`endif

// [logic/mst_timebase.v]
// Time-base prescaler with sticky overflow latch.
// Assumes one step per instruction cycle on i_step.
`timescale 1ns/1ns
`include "mst_defs.vh"
module mst_timebase #(
  parameter TB_W = `MST_TB_W
) (
  // Clock and reset.
  input wire i_core_clk,
  input wire i_rst_b,
  // Control.
  input wire i_step,
  input wire i_clear,
  // Status.
  output reg o_ovf,
  output reg [TB_W-1:0] o_count
);
  wire wrap;
  assign wrap = i_step & (&o_count);
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_count <= {TB_W{1'b0}};
      o_ovf <= 1'b0;
    end else begin
      if (i_step) begin
        o_count <= o_count + {{(TB_W-1){1'b0}}, 1'b1}; // [RL6]
      end
      // A wrap in the clearing cycle wins so no tick is lost.
      if (wrap) begin
        o_ovf <= 1'b1; // [RL6] [RL20]
      end else if (i_clear) begin
        o_ovf <= 1'b0; // [RL7]
      end
    end
  end
endmodule

// [logic/mst_sequencer.v]
// Program sequencer: counter, return stack, table load, skip and options.
// Assumes a ROM answering combinationally on o_rom_addr / i_rom_data and
// an Avalon-MM master issuing operations through registers.
`timescale 1ns/1ns
`include "mst_defs.vh"
module mst_sequencer #(
  parameter PC_W = `MST_PC_W
) (
  // Clock and reset.
  input wire i_core_clk,
  input wire i_rst_b,
  // Avalon-MM slave.
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // Program ROM.
  output reg [PC_W-1:0] o_rom_addr,
  input wire [7:0] i_rom_data,
  // Serial pins.
  input wire i_serial_in,
  input wire i_serial_out_forced,
  output reg o_serial_data_gpo_en,
  output reg o_serial_clock_pin_gpo_en,
  // Test modes.
  output reg o_test_ram_logic,
  output reg o_test_rom,
  // Clock option results.
  output reg [4:0] o_clk_div,
  output reg o_clock_aux_pin_osc
);
  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_SECOND = 3'b100;
  reg [2:0] state_reg;
  reg [PC_W-1:0] pc_reg;
  reg [PC_W-1:0] stack_level_top_reg;
  reg [PC_W-1:0] stack_level_mid_reg;
  reg [PC_W-1:0] stack_level_bottom_reg;
  reg [7:0] table_reg;
  reg [2:0] op_reg;
  reg [3:0] acc_reg;
  reg [3:0] ram_reg;
  reg [5:0] arg_reg;
  reg [1:0] skip_bytes_reg;
  reg [1:0] skip_cnt_reg;
  reg [2:0] clock_in_pin_opt_reg;
  reg [2:0] clock_aux_pin_opt_reg;
  reg func_opt_reg;
  reg reduced_pin_reg;
  reg shift_counter_reg_mode_reg;
  reg opt_err_reg;
  wire tb_ovf;
  wire [9:0] tb_count;
  wire tb_clear;
  ////////////////////////////////////////////////////////////////////////
  function [PC_W-1:0] inc_pc;
    input [PC_W-1:0] pc;
    begin
      inc_pc = pc + {{(PC_W-1){1'b0}}, 1'b1}; // [RL9]
    end
  endfunction
  // Page base seen by an instruction: the next page when in the last word.
  function [PC_W-1:0] cur_page;
    input [PC_W-1:0] pc;
    begin
      if (pc[5:0] == 6'h3F) begin
        cur_page = inc_pc(pc); // [RL10] [RL11]
      end else begin
        cur_page = pc;
      end
    end
  endfunction
  function [4:0] div_of;
    input [2:0] code;
    begin
      case (code)
        3'h0, 3'h2: div_of = 5'h10; // [RL13]
        3'h1, 3'h3: div_of = 5'h08; // [RL13]
        3'h4, 3'h5: div_of = 5'h04; // [RL13]
        default: div_of = 5'h10;
      endcase
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////
  wire [PC_W-1:0] page_pc;
  wire [PC_W-1:0] table_addr;
  assign page_pc = cur_page(pc_reg);
  // Top two page bits, then accumulator, then RAM nibble.
  assign table_addr = {page_pc[9:8], acc_reg, ram_reg}; // [RL1] [RL2]
  assign tb_clear = (state_reg == ST_EXEC) && (op_reg == `MST_OP_SKT) &&
                    (skip_cnt_reg == 2'h0) && tb_ovf;
  // Free-running once per instruction cycle; the bus clock is that cycle.
  mst_timebase #(
    .TB_W(10)
  ) u_timebase (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_step(1'b1),
    .i_clear(tb_clear),
    .o_ovf(tb_ovf),
    .o_count(tb_count)
  );
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
      pc_reg <= `MST_PC_RST;
      stack_level_top_reg <= 10'h000;
      stack_level_mid_reg <= 10'h000;
      stack_level_bottom_reg <= 10'h000;
      table_reg <= 8'h00;
      op_reg <= `MST_OP_NONE;
      acc_reg <= 4'h0;
      ram_reg <= 4'h0;
      arg_reg <= 6'h00;
      skip_bytes_reg <= 2'h0;
      skip_cnt_reg <= 2'h0;
      clock_in_pin_opt_reg <= 3'h0;
      clock_aux_pin_opt_reg <= 3'h0;
      func_opt_reg <= 1'b0;
      reduced_pin_reg <= 1'b0;
      shift_counter_reg_mode_reg <= 1'b0;
      opt_err_reg <= 1'b0;
      o_rom_addr <= `MST_PC_RST;
      o_avs_readdata <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= 1'b1;
      o_rom_addr <= pc_reg;
      case (state_reg)
        ST_IDLE: begin
          if ((i_avs_write || i_avs_read) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
            if (i_avs_write) begin
              case (i_avs_address)
                `MST_REG_CTRL: begin
                  if (i_avs_writedata[`MST_CTRL_GO]) begin
                    op_reg <= i_avs_writedata[3:1];
                    acc_reg <= i_avs_writedata[7:4];
                    ram_reg <= i_avs_writedata[11:8];
                    arg_reg <= i_avs_writedata[17:12];
                    skip_bytes_reg <= i_avs_writedata[19:18];
                    skip_cnt_reg <= 2'h0;
                    state_reg <= ST_EXEC;
                  end
                end
                `MST_REG_OPT: begin
                  clock_in_pin_opt_reg <= i_avs_writedata[2:0];
                  clock_aux_pin_opt_reg <= i_avs_writedata[6:4];
                  reduced_pin_reg <= i_avs_writedata[9];
                  // Parallel bus option forced off on the reduced-pin part.
                  func_opt_reg <= i_avs_writedata[8] &
                                  ~i_avs_writedata[9]; // [RL15]
                  shift_counter_reg_mode_reg <= i_avs_writedata[12];
                  opt_err_reg <= (i_avs_writedata[6:4] == 3'h0) &&
                    (i_avs_writedata[2:0] == 3'h4 ||
                     i_avs_writedata[2:0] == 3'h5); // [RL14]
                end
                `MST_REG_PC: pc_reg <= i_avs_writedata[9:0];
                default: begin
                end
              endcase
            end else begin
              case (i_avs_address)
                `MST_REG_OPT: o_avs_readdata <= {19'h0,
                  shift_counter_reg_mode_reg, 2'h0, reduced_pin_reg,
                  func_opt_reg, 1'b0, clock_aux_pin_opt_reg, 1'b0,
                  clock_in_pin_opt_reg};
                `MST_REG_STAT: o_avs_readdata <= {29'h0, opt_err_reg,
                  1'b0, tb_ovf};
                `MST_REG_PC: o_avs_readdata <= {22'h0, pc_reg};
                `MST_REG_TABLE: o_avs_readdata <= {24'h0, table_reg};
                `MST_REG_STK0: o_avs_readdata <= {22'h0,
                  stack_level_top_reg};
                `MST_REG_STK1: o_avs_readdata <= {22'h0,
                  stack_level_mid_reg};
                `MST_REG_STK2: o_avs_readdata <= {22'h0,
                  stack_level_bottom_reg};
                `MST_REG_TBASE: o_avs_readdata <= {22'h0, tb_count};
                default: o_avs_readdata <= 32'h0000_0000;
              endcase
            end
          end
        end
        ST_EXEC: begin
          // A pending skip burns one cycle per byte, nothing executes.
          if (skip_cnt_reg != 2'h0) begin
            pc_reg <= inc_pc(pc_reg); // [RL8]
            skip_cnt_reg <= skip_cnt_reg - 2'h1; // [RL8]
            if (skip_cnt_reg == 2'h1) begin
              state_reg <= ST_IDLE;
            end
          end else begin
            case (op_reg)
              `MST_OP_TABLE: begin
                // Push PC+1, address table with A and RAM nibble.
                stack_level_top_reg <= inc_pc(pc_reg); // [RL2] [RL19]
                stack_level_mid_reg <= stack_level_top_reg; // [RL19]
                stack_level_bottom_reg <= stack_level_mid_reg; // [RL4]
                pc_reg <= table_addr; // [RL2]
                o_rom_addr <= table_addr; // [RL1]
                state_reg <= ST_SECOND; // [RL5]
              end
              `MST_OP_JIND: begin
                o_rom_addr <= table_addr; // [RL11]
                state_reg <= ST_SECOND; // [RL18]
              end
              `MST_OP_SKT: begin
                pc_reg <= inc_pc(pc_reg);
                if (tb_ovf && skip_bytes_reg != 2'h0) begin
                  skip_cnt_reg <= skip_bytes_reg; // [RL7]
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
              `MST_OP_JPAGE: begin
                pc_reg <= {page_pc[9:6], arg_reg}; // [RL10]
                state_reg <= ST_IDLE;
              end
              `MST_OP_CALLP: begin
                stack_level_top_reg <= inc_pc(pc_reg); // [RL19]
                stack_level_mid_reg <= stack_level_top_reg;
                stack_level_bottom_reg <= stack_level_mid_reg;
                pc_reg <= {4'h2, arg_reg};
                state_reg <= ST_IDLE;
              end
              `MST_OP_RET: begin
                pc_reg <= stack_level_top_reg; // [RL19]
                stack_level_top_reg <= stack_level_mid_reg;
                stack_level_mid_reg <= stack_level_bottom_reg;
                state_reg <= ST_IDLE;
              end
              `MST_OP_SEQ: begin
                pc_reg <= inc_pc(pc_reg); // [RL9]
                state_reg <= ST_IDLE;
              end
              default: state_reg <= ST_IDLE;
            endcase
          end
        end
        ST_SECOND: begin
          if (op_reg == `MST_OP_TABLE) begin
            table_reg <= i_rom_data; // [RL1]
            // Pop: bottom keeps its value, so it ends holding old middle.
            pc_reg <= stack_level_top_reg; // [RL3]
            stack_level_top_reg <= stack_level_mid_reg; // [RL3]
            stack_level_mid_reg <= stack_level_bottom_reg; // [RL4]
          end else begin
            // The last word of a page group lands in the next group.
            pc_reg <= {page_pc[9:8], i_rom_data}; // [RL18] [RL11]
          end
          state_reg <= ST_IDLE; // [RL5]
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_serial_data_gpo_en <= 1'b0;
      o_serial_clock_pin_gpo_en <= 1'b0;
      o_test_ram_logic <= 1'b0;
      o_test_rom <= 1'b0;
      o_clk_div <= 5'h10;
      o_clock_aux_pin_osc <= 1'b0;
    end else begin
      o_serial_data_gpo_en <= shift_counter_reg_mode_reg; // [RL17]
      o_serial_clock_pin_gpo_en <= shift_counter_reg_mode_reg; // [RL17]
      o_test_ram_logic <= i_serial_out_forced & i_serial_in; // [RL16]
      o_test_rom <= i_serial_out_forced & ~i_serial_in; // [RL16]
      o_clk_div <= div_of(clock_in_pin_opt_reg); // [RL13]
      // An illegal pairing leaves the oscillator drive off.
      o_clock_aux_pin_osc <= (clock_aux_pin_opt_reg == 3'h0) &
                             ~opt_err_reg; // [RL14]
    end
  end
endmodule

// [tb/mst_rom_model.sv]
// Program ROM model for the sequencer bench.
// Assumes the sequencer reads it combinationally on a 10-bit address.
`timescale 1ns/1ns
module mst_rom_model #(
  parameter logic [7:0] CLEAR_OP = 8'h00
) (
  input wire logic [9:0] i_addr,
  output logic [7:0] o_data
);
  // Word zero holds the clear-accumulator op; the rest is a known pattern.
  assign o_data = (i_addr == 10'h000) ? CLEAR_OP :
                  (i_addr[7:0] ^ 8'hA5);
endmodule

// [tb/mst_seq_checker.sv]
// Assertions on the sequencer ports.
// Assumes Avalon-MM writes take effect at the edge waitrequest is low.
`timescale 1ns/1ns
module mst_seq_checker #(
  parameter PC_W = 10
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire [3:0] i_avs_address,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire o_avs_waitrequest,
  input wire [PC_W-1:0] o_rom_addr,
  input wire i_serial_in,
  input wire i_serial_out_forced,
  input wire o_serial_data_gpo_en,
  input wire o_serial_clock_pin_gpo_en,
  input wire o_test_ram_logic,
  input wire o_test_rom,
  input wire [4:0] o_clk_div,
  input wire o_clock_aux_pin_osc
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  //////////////////////////////////////////////////////////////
  wire [31:0] wd = i_avs_writedata;
  wire wr_acc = i_avs_write && !o_avs_waitrequest;
  wire opt_acc = wr_acc && (i_avs_address == 4'h1);
  wire tbl_go = wr_acc && (i_avs_address == 4'h0) && (wd[3:0] == 4'h3);
  reg [PC_W-1:0] pc_w, tbl_e, ret_e;
  reg [4:0] div_e;
  reg osc_e, gpo_e;
  wire [PC_W-1:0] pc_p1 = pc_w + 1'b1;
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pc_w <= '0;
      tbl_e <= '0;
      ret_e <= '0;
      div_e <= 5'h10;
      osc_e <= 1'b0;
      gpo_e <= 1'b0;
    end else begin
      if (wr_acc && (i_avs_address == 4'h3)) pc_w <= wd[PC_W-1:0];
      if (tbl_go) begin
        tbl_e <= {pc_p1[PC_W-1:8], wd[7:4], wd[11:8]};
        ret_e <= pc_p1;
      end
      if (opt_acc) begin
        div_e <= (wd[2:1] == 2'h2) ? 5'h04 : (wd[0] ? 5'h08 : 5'h10);
        osc_e <= (wd[6:4] == 3'h0) && (wd[2:0] < 3'h4);
        gpo_e <= wd[12];
      end
    end
  end
  //////////////////////////////////////////////////////////////
  a_ram_test_mode: assert property (1'b1 |=>
    o_test_ram_logic == $past(i_serial_out_forced && i_serial_in))
    else $error("ram test flag wrong");
  a_rom_test_mode: assert property (1'b1 |=>
    o_test_rom == $past(i_serial_out_forced && !i_serial_in))
    else $error("rom test flag wrong");
  a_div_select: assert property (opt_acc |-> ##2 o_clk_div == div_e)
    else $error("clock divisor wrong");
  a_reset_divisor: assert property ($rose(i_rst_b) |-> o_clk_div == 5'h10)
    else $error("reset divisor wrong");
  a_osc_barred: assert property (opt_acc |-> ##2 o_clock_aux_pin_osc == osc_e)
    else $error("aux pin drive wrong");
  a_gpo_data_free: assert property (opt_acc |-> ##2 o_serial_data_gpo_en == gpo_e)
    else $error("data pin release wrong");
  a_gpo_clock_free: assert property (opt_acc |-> ##2 o_serial_clock_pin_gpo_en == gpo_e)
    else $error("clock pin release wrong");
  // The table address must show, then the return address, within the op.
  a_table_fetch: assert property (tbl_go |-> ##[1:3] (o_rom_addr == tbl_e)
    ##[1:2] (o_rom_addr == ret_e)) else $error("table fetch address wrong");
  c_table: cover property (tbl_go);
  c_div4: cover property (opt_acc ##2 o_clk_div == 5'h04);
  c_rom_test: cover property (o_test_rom);
endmodule
bind mst_sequencer mst_seq_checker #(.PC_W(PC_W)) u_chk (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_rom_addr(o_rom_addr),
  .i_serial_in(i_serial_in), .i_serial_out_forced(i_serial_out_forced),
  .o_serial_data_gpo_en(o_serial_data_gpo_en),
  .o_serial_clock_pin_gpo_en(o_serial_clock_pin_gpo_en),
  .o_test_ram_logic(o_test_ram_logic), .o_test_rom(o_test_rom),
  .o_clk_div(o_clk_div), .o_clock_aux_pin_osc(o_clock_aux_pin_osc));

// [tb/tb_top.sv]
// Self-checking bench for the sequencer.
// Assumes one request at a time on the register bus, answered in bounded time.
`timescale 1ns/1ns
module tb_top;
  typedef struct {logic [15:0] opt; logic [4:0] div; logic err; logic fn;} mst_row_t;
  mst_row_t rows [6] = '{'{16'h0100, 5'h10, 1'b0, 1'b1},
    '{16'h1321, 5'h08, 1'b0, 1'b0}, '{16'h0032, 5'h10, 1'b0, 1'b0},
    '{16'h1043, 5'h08, 1'b0, 1'b0}, '{16'h0014, 5'h04, 1'b0, 1'b0},
    '{16'h0005, 5'h04, 1'b1, 1'b0}};
  logic i_core_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic ser_in = 1'b0;
  logic ser_forced = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q, v1;
  logic wait_req, gpo_d, gpo_c, t_ram, t_rom, osc;
  logic [9:0] rom_addr;
  logic [7:0] rom_data;
  logic [4:0] div;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int c1;
  mst_sequencer u_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_rom_addr(rom_addr),
    .i_rom_data(rom_data), .i_serial_in(ser_in),
    .i_serial_out_forced(ser_forced), .o_serial_data_gpo_en(gpo_d),
    .o_serial_clock_pin_gpo_en(gpo_c), .o_test_ram_logic(t_ram),
    .o_test_rom(t_rom), .o_clk_div(div), .o_clock_aux_pin_osc(osc));
  mst_rom_model u_rom (.i_addr(rom_addr), .o_data(rom_data));
  //////////////////////////////////////////////////////////////
  always #5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request is held until waitrequest is seen low at a rising edge.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0) n_errors++;
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  function logic [31:0] cw(input logic [2:0] o, input logic [3:0] a,
      input logic [3:0] m, input logic [5:0] t, input logic [1:0] s);
    return {12'h0, s, t, m, a, o, 1'b1};
  endfunction
  // Runs one op from a given counter value and leaves the new counter in q.
  task op(input logic [9:0] pc, input logic [31:0] c);
    bus(1'b1, 4'h3, {22'h0, pc});
    bus(1'b1, 4'h0, c);
    bus(1'b0, 4'h3, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, 4'h1, {16'h0, rows[i].opt});
      bus(1'b0, 4'h2, 32'h0);
      chk(q[2], rows[i].err);
      chk(div, rows[i].div);
      chk(gpo_d, rows[i].opt[12]);
      chk(gpo_c, rows[i].opt[12]);
      chk(osc, rows[i].opt[6:4] == 3'h0 && rows[i].opt[2:0] < 3'h4);
      bus(1'b0, 4'h1, 32'h0);
      chk(q[8], rows[i].fn);
    end
    $display("option rows done");
    bus(1'b0, 4'h8, 32'h0);
    v1 = q;
    c1 = cyc;
    bus(1'b0, 4'h8, 32'h0);
    chk((q - v1) & 32'h3FF, (cyc - c1) & 32'h3FF);
    bus(1'b0, 4'hF, 32'h0);
    chk(q, 32'h0);
    repeat (1100) @(posedge i_core_clk);
    bus(1'b0, 4'h2, 32'h0);
    chk(q[0], 1'b1);
    op(10'h050, cw(3'h2, 4'h0, 4'h0, 6'h00, 2'h2));
    chk(q, 32'h053);
    bus(1'b0, 4'h2, 32'h0);
    chk(q[0], 1'b0);
    op(10'h050, cw(3'h2, 4'h0, 4'h0, 6'h00, 2'h2));
    chk(q, 32'h051);
    $display("time base done");
    op(10'h010, cw(3'h5, 4'h0, 4'h0, 6'h01, 2'h0));
    chk(q, 32'h081);
    op(10'h020, cw(3'h5, 4'h0, 4'h0, 6'h01, 2'h0));
    op(10'h030, cw(3'h5, 4'h0, 4'h0, 6'h01, 2'h0));
    op(10'h200, cw(3'h1, 4'h1, 4'h2, 6'h00, 2'h0));
    chk(q, 32'h201);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0B7);
    bus(1'b0, 4'h7, 32'h0);
    chk(q, 32'h021);
    bus(1'b0, 4'h6, 32'h0);
    chk(q, 32'h021);
    bus(1'b1, 4'h0, cw(3'h6, 4'h0, 4'h0, 6'h00, 2'h0));
    bus(1'b0, 4'h3, 32'h0);
    chk(q, 32'h031);
    $display("stack done");
    op(10'h03F, cw(3'h7, 4'h0, 4'h0, 6'h00, 2'h0));
    chk(q, 32'h040);
    op(10'h3FF, cw(3'h7, 4'h0, 4'h0, 6'h00, 2'h0));
    chk(q, 32'h000);
    op(10'h07F, cw(3'h4, 4'h0, 4'h0, 6'h05, 2'h0));
    chk(q, 32'h085);
    op(10'h123, cw(3'h3, 4'h4, 4'h7, 6'h00, 2'h0));
    chk(q, 32'h1E2);
    op(10'h0FF, cw(3'h1, 4'h3, 4'h9, 6'h00, 2'h0));
    chk(q, 32'h100);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h09C);
    op(10'h0FF, cw(3'h3, 4'h3, 4'h9, 6'h00, 2'h0));
    chk(q, 32'h19C);
    $display("paging done");
    ser_forced <= 1'b1;
    ser_in <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    chk(t_ram, 1'b1);
    ser_in <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk({t_ram, t_rom}, 2'b01);
    ser_forced <= 1'b0;
    $display("test mode done");
    final_report;
  end
endmodule
